// *** rtl/htss_top.v ***
// Hold mode, trigger and state store logic with APB register access
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "htss_defines.vh"
module htss_top #(
  parameter NUM_STATES = 16,
  parameter IDX_W      = 4,
  parameter SET_W      = 16,
  parameter MASK_W     = 8
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              bus_trigger,
  output reg  [SET_W-1:0]  voltage_setpoint,
  output reg  [SET_W-1:0]  current_setpoint,
  output reg  [1:0]        mode_trip_shutdown,
  output reg  [MASK_W-1:0] fault_mask,
  output reg               output_enable,
  output reg               irq
);
  localparam SNAP_W = 2 * SET_W + 2 + MASK_W;

  // ****************************************
  // Synchroniser for the bus trigger pin
  // ****************************************
  reg trg_s1;
  reg trg_s2;
  reg trg_s3;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trg_s1 <= 1'b0;
      trg_s2 <= 1'b0;
      trg_s3 <= 1'b0;
    end else begin
      trg_s1 <= bus_trigger;
      trg_s2 <= trg_s1;
      trg_s3 <= trg_s2;
    end
  end
  // Two flops settle the pin; the third only marks the rising edge,
  // so nothing but the second flop reads the first
  wire bus_trig_pulse = trg_s2 & ~trg_s3;

  // ****************************************
  // APB decode
  // ****************************************
  wire wr_acc = psel & penable & pwrite & pready;
  wire rd_acc = psel & penable & ~pwrite & pready;
  wire [11:0] waddr = paddr;
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `HTSS_MISC_OFF);
  wire wr_setpt = wr_acc & (waddr == `HTSS_SETPT_OFF);
  wire wr_misc  = wr_acc & (waddr == `HTSS_MISC_OFF);
  wire wr_ctrl  = wr_acc & (waddr == `HTSS_CTRL_OFF);
  wire wr_cmd   = wr_acc & (waddr == `HTSS_CMD_OFF);
  wire wr_mask  = wr_acc & (waddr == `HTSS_IRQ_MASK_OFF);
  wire rd_stat  = rd_acc & (paddr == `HTSS_IRQ_STAT_OFF);
  wire [3:0]       cmd_code = pwdata[3:0];
  wire [7:0]       cmd_num  = pwdata[15:8];
  // Number wider than the index so out of range values are caught
  wire             num_ok   = (cmd_num < NUM_STATES);
  wire [IDX_W-1:0] cmd_idx  = cmd_num[IDX_W-1:0];

  // ****************************************
  // Settings, two ranks
  // ****************************************
  reg              hold_mode;
  reg [SET_W-1:0]  buf_volt;
  reg [SET_W-1:0]  buf_curr;
  reg [1:0]        buf_trip;
  reg [MASK_W-1:0] buf_mask;
  reg [3:0]        last_error;
  reg [3:0]        irq_stat;
  reg [3:0]        irq_mask;

  wire trig_cmd   = wr_cmd & (cmd_code == `HTSS_CMD_TRIGGER);
  wire trig_any   = trig_cmd | bus_trig_pulse;
  wire save_cmd   = wr_cmd & (cmd_code == `HTSS_CMD_SAVE);
  wire rest_cmd   = wr_cmd & (cmd_code == `HTSS_CMD_RESTORE);
  wire reinit_cmd = wr_cmd & (cmd_code == `HTSS_CMD_REINIT);
  wire save_ok    = save_cmd & num_ok;
  wire rest_ok    = rest_cmd & num_ok;
  wire range_err  = (save_cmd | rest_cmd) & ~num_ok;

  wire [SNAP_W-1:0] snap_rd;
  // Snapshot holds the active rank; output enable is left out
  wire [SNAP_W-1:0] snap_wr = {voltage_setpoint, current_setpoint,
                               mode_trip_shutdown, fault_mask};

  htss_snapshot_store #(
    .DEPTH  (NUM_STATES),
    .IDX_W  (IDX_W),
    .DATA_W (SNAP_W)
  ) u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (save_ok),
    .wr_idx  (cmd_idx),
    .wr_data (snap_wr),
    .rd_idx  (cmd_idx),
    .rd_data (snap_rd)
  );

  // ****************************************
  // Next values of both ranks
  // ****************************************
  // Priority: reinitialise, then recall, then trigger, then a write
  reg [SET_W-1:0]  next_buf_volt;
  reg [SET_W-1:0]  next_buf_curr;
  reg [1:0]        next_buf_trip;
  reg [MASK_W-1:0] next_buf_mask;
  reg [SET_W-1:0]  next_volt;
  reg [SET_W-1:0]  next_curr;
  reg [1:0]        next_trip;
  reg [MASK_W-1:0] next_mask;

  // First rank buffers take every write
  always @* begin
    next_buf_volt = buf_volt;
    next_buf_curr = buf_curr;
    next_buf_trip = buf_trip;
    next_buf_mask = buf_mask;
    if (reinit_cmd) begin
      next_buf_volt = `HTSS_RST_VOLT;
      next_buf_curr = `HTSS_RST_CURR;
      next_buf_trip = `HTSS_TRIP_OFF;
      next_buf_mask = `HTSS_RST_MASK;
    end else if (rest_ok) begin
      {next_buf_volt, next_buf_curr, next_buf_trip, next_buf_mask} = snap_rd;
    end else begin
      if (wr_setpt) begin
        next_buf_volt = pwdata[31:16];
        next_buf_curr = pwdata[15:0];
      end
      if (wr_misc) begin
        next_buf_trip = pwdata[9:8];
        next_buf_mask = pwdata[MASK_W-1:0];
      end
    end
  end

  // Second rank: direct outside hold, else only on trigger, recall or reinitialise
  always @* begin
    next_volt = voltage_setpoint;
    next_curr = current_setpoint;
    next_trip = mode_trip_shutdown;
    next_mask = fault_mask;
    if (reinit_cmd) begin
      next_volt = `HTSS_RST_VOLT;
      next_curr = `HTSS_RST_CURR;
      next_trip = `HTSS_TRIP_OFF;
      next_mask = `HTSS_RST_MASK;
    end else if (rest_ok) begin
      // Recall applies at once, hold or not
      {next_volt, next_curr, next_trip, next_mask} = snap_rd;
    end else if (trig_any) begin
      // Copy the buffers as they stand after this edge, so a write
      // that meets a pin trigger is not lost
      next_volt = next_buf_volt;
      next_curr = next_buf_curr;
      next_trip = next_buf_trip;
      next_mask = next_buf_mask;
    end else if (!hold_mode) begin
      if (wr_setpt) begin
        next_volt = pwdata[31:16];
        next_curr = pwdata[15:0];
      end
      if (wr_misc) begin
        next_trip = pwdata[9:8];
        next_mask = pwdata[MASK_W-1:0];
      end
    end
  end

  // Both ranks load on every edge from the values above
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_volt           <= `HTSS_RST_VOLT;
      buf_curr           <= `HTSS_RST_CURR;
      buf_trip           <= `HTSS_TRIP_OFF;
      buf_mask           <= `HTSS_RST_MASK;
      voltage_setpoint   <= `HTSS_RST_VOLT;
      current_setpoint   <= `HTSS_RST_CURR;
      mode_trip_shutdown <= `HTSS_TRIP_OFF;
      fault_mask         <= `HTSS_RST_MASK;
    end else begin
      buf_volt           <= next_buf_volt;
      buf_curr           <= next_buf_curr;
      buf_trip           <= next_buf_trip;
      buf_mask           <= next_buf_mask;
      voltage_setpoint   <= next_volt;
      current_setpoint   <= next_curr;
      mode_trip_shutdown <= next_trip;
      fault_mask         <= next_mask;
    end
  end

  // ****************************************
  // Mode, output enable and error code
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_mode     <= 1'b0;
      output_enable <= 1'b0;
      last_error    <= `HTSS_ERR_NONE;
    end else begin
      if (wr_cmd && cmd_code == `HTSS_CMD_HOLD_ON) begin
        hold_mode <= 1'b1;
      end else if (wr_cmd && cmd_code == `HTSS_CMD_HOLD_OFF) begin
        hold_mode <= 1'b0;
      end else if (wr_ctrl) begin
        hold_mode <= pwdata[0];
      end
      if (wr_cmd && cmd_code == `HTSS_CMD_OUT_OFF) begin
        output_enable <= 1'b0;
      end else if (wr_cmd && cmd_code == `HTSS_CMD_OUT_ON) begin
        output_enable <= 1'b1;
      end
      if (range_err) begin
        last_error <= `HTSS_ERR_RANGE;
      end else if (wr_ctrl && pwdata[1]) begin
        last_error <= `HTSS_ERR_NONE;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  wire [3:0] irq_evt;
  assign irq_evt[`HTSS_IRQ_TRIG_BIT] = trig_any;
  assign irq_evt[`HTSS_IRQ_SAVE_BIT] = save_ok;
  assign irq_evt[`HTSS_IRQ_REST_BIT] = rest_ok;
  assign irq_evt[`HTSS_IRQ_ERR_BIT]  = range_err;
  // A read clears only the bits it returned: an event that lands
  // between the setup edge and the access edge stays pending
  wire [3:0] stat_clr      = rd_stat ? prdata[3:0] : 4'h0;
  // Set wins over the clear by read, so no event is lost
  wire [3:0] next_irq_stat = (irq_stat & ~stat_clr) | irq_evt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      if (wr_mask) begin
        irq_mask <= pwdata[3:0];
      end
      irq <= |(next_irq_stat & (wr_mask ? pwdata[3:0] : irq_mask));
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `HTSS_CTRL_OFF:      rd_mux = {31'h0, hold_mode};
      `HTSS_ACT_SETPT_OFF: rd_mux = {voltage_setpoint, current_setpoint};
      `HTSS_ACT_MISC_OFF:  rd_mux = {22'h0, mode_trip_shutdown, fault_mask};
      `HTSS_STATUS_OFF:    rd_mux = {24'h0, last_error, 2'h0,
                                     output_enable, hold_mode};
      `HTSS_IRQ_STAT_OFF:  rd_mux = {28'h0, irq_stat};
      `HTSS_IRQ_MASK_OFF:  rd_mux = {28'h0, irq_mask};
      `HTSS_BUF_SETPT_OFF: rd_mux = {buf_volt, buf_curr};
      `HTSS_BUF_MISC_OFF:  rd_mux = {22'h0, buf_trip, buf_mask};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // APB answer state
  // ****************************************
  // Two states: every transfer gets one access cycle with pready high.
  // Back to back transfers work, since the access edge returns to idle
  // and the next setup cycle is seen from there.
  localparam ST_IDLE = 1'b0;
  localparam ST_ACK  = 1'b1;
  reg              state;
  reg              next_state;

  always @* begin
    case (state)
      ST_IDLE: begin
        next_state = (psel && !penable) ? ST_ACK : ST_IDLE;
      end
      ST_ACK: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // No wait state: pready rises in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_IDLE;
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state == ST_ACK) begin
        pready  <= 1'b1;
        prdata  <= rd_mux;
        pslverr <= ~mapped;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end
endmodule // htss_top

// *** rtl/htss_defines.vh ***
// Constants for the hold, trigger and state store block
`ifndef HTSS_DEFINES_VH
`define HTSS_DEFINES_VH
// Register byte offsets
`define HTSS_CTRL_OFF       12'h000
`define HTSS_SETPT_OFF      12'h004
`define HTSS_CMD_OFF        12'h008
`define HTSS_ACT_SETPT_OFF  12'h00C
`define HTSS_ACT_MISC_OFF   12'h010
`define HTSS_STATUS_OFF     12'h014
`define HTSS_IRQ_STAT_OFF   12'h018
`define HTSS_IRQ_MASK_OFF   12'h01C
`define HTSS_BUF_SETPT_OFF  12'h020
`define HTSS_BUF_MISC_OFF   12'h024
`define HTSS_MISC_OFF       12'h028
// Command codes in CMD[3:0], register number in CMD[15:8]
`define HTSS_CMD_TRIGGER    4'h1
`define HTSS_CMD_SAVE       4'h2
`define HTSS_CMD_RESTORE    4'h3
`define HTSS_CMD_REINIT     4'h4
`define HTSS_CMD_OUT_OFF    4'h5
`define HTSS_CMD_OUT_ON     4'h6
`define HTSS_CMD_HOLD_OFF   4'h7
`define HTSS_CMD_HOLD_ON    4'h8
// Error codes
`define HTSS_ERR_NONE       4'h0
`define HTSS_ERR_RANGE      4'h5
// Mode trip shutdown encodings
`define HTSS_TRIP_OFF       2'h0
`define HTSS_TRIP_CC        2'h1
`define HTSS_TRIP_CV        2'h2
// Interrupt status bits
`define HTSS_IRQ_TRIG_BIT   0
`define HTSS_IRQ_SAVE_BIT   1
`define HTSS_IRQ_REST_BIT   2
`define HTSS_IRQ_ERR_BIT    3
`define HTSS_IRQ_W          4
// Reset values of settings
`define HTSS_RST_VOLT       16'h0000
`define HTSS_RST_CURR       16'h0000
`define HTSS_RST_MASK       8'h00
`endif

// *** rtl/htss_snapshot_store.v ***
// Numbered snapshot store of operating settings
`timescale 1ns/1ps
`include "htss_defines.vh"
module htss_snapshot_store #(
  parameter DEPTH = 16,
  parameter IDX_W = 4,
  parameter DATA_W = 42
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              wr_en,
  input  wire [IDX_W-1:0]  wr_idx,
  input  wire [DATA_W-1:0] wr_data,
  input  wire [IDX_W-1:0]  rd_idx,
  output wire [DATA_W-1:0] rd_data
);
  // ****************************************
  // Storage
  // ****************************************
  reg [DATA_W-1:0] mem [0:DEPTH-1];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_entry
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem[g] <= {DATA_W{1'b0}};
        end else if (wr_en && (wr_idx == g)) begin
          mem[g] <= wr_data;
        end
      end
    end
  endgenerate
  // Any entry may be read in any order
  assign rd_data = mem[rd_idx];
endmodule // htss_snapshot_store

// *** verif/htss_top_props.sv ***
// Checker for the hold, trigger and state store block
`timescale 1ns/1ps
module htss_top_props #(parameter SET_W = 16, parameter MASK_W = 8) (
  input wire              pclk,
  input wire              presetn,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [11:0]       paddr,
  input wire [31:0]       pwdata,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  input wire              bus_trigger,
  input wire [SET_W-1:0]  voltage_setpoint,
  input wire [SET_W-1:0]  current_setpoint,
  input wire [1:0]        mode_trip_shutdown,
  input wire [MASK_W-1:0] fault_mask,
  input wire              output_enable,
  input wire              irq
);
  // ******
  // Hold tracking
  // ******
  wire      wr   = psel && penable && pready && pwrite;
  wire      cmd  = wr && paddr == 12'h008;
  wire      setp = wr && paddr == 12'h004;
  wire [3:0] op  = pwdata[3:0];
  reg       hold;
  reg [5:0] th;
  // Trigger pin history masks the synchroniser delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= 1'b0;
      th <= 6'h00;
    end else begin
      th <= {th[4:0], bus_trigger};
      if (wr && paddr == 12'h000) hold <= pwdata[0];
      else if (cmd && op == 4'h7) hold <= 1'b0;
      else if (cmd && op == 4'h8) hold <= 1'b1;
    end
  end
  wire quiet = th == 6'h00 && !bus_trigger;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ******
  // Properties
  // ******
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_err; psel && !penable && (paddr > 12'h028 || paddr[1:0] != 2'h0) |=> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_hold; setp && hold && quiet |=> $stable({voltage_setpoint, current_setpoint});
  endproperty
  a_hold: assert property (p_hold) else $error("active rank moved in hold");
  property p_direct; setp && !hold && quiet |=>
    {voltage_setpoint, current_setpoint} == $past(pwdata); endproperty
  a_direct: assert property (p_direct) else $error("setting not applied");
  property p_bad; cmd && pwdata[3:1] == 3'h1 && pwdata[15:12] != 4'h0 && quiet |=>
    $stable({voltage_setpoint, current_setpoint, mode_trip_shutdown, fault_mask}); endproperty
  a_bad: assert property (p_bad) else $error("bad number changed state");
  property p_off; cmd && op == 4'h5 |=> !output_enable; endproperty
  a_off: assert property (p_off) else $error("output not off");
  property p_on; cmd && op == 4'h6 |=> output_enable; endproperty
  a_on: assert property (p_on) else $error("output not on");
  property p_reinit; cmd && op == 4'h4 |=> $stable(output_enable) &&
    !(|{voltage_setpoint, current_setpoint, mode_trip_shutdown, fault_mask}); endproperty
  a_reinit: assert property (p_reinit) else $error("reinit wrong");
  c_trig: cover property ($rose(bus_trigger));
  c_save: cover property (cmd && op == 4'h2);
  c_err: cover property (pslverr);
endmodule // htss_top_props
bind htss_top htss_top_props #(.SET_W(SET_W), .MASK_W(MASK_W)) i_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bus_trigger(bus_trigger), .voltage_setpoint(voltage_setpoint),
  .current_setpoint(current_setpoint), .mode_trip_shutdown(mode_trip_shutdown),
  .fault_mask(fault_mask), .output_enable(output_enable), .irq(irq));

// *** verif/htss_host_model.sv ***
// Host side model driving the group trigger line
`timescale 1ns/1ps
module htss_host_model (
  input  wire pclk,
  input  wire presetn,
  input  wire fire,
  output reg  bus_trigger
);
  reg [2:0] cnt;
  // High two cycles, low at least four, so edges stay spaced
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_trigger <= 1'b0;
      cnt <= 3'h0;
    end else if (fire && cnt == 3'h0) begin
      bus_trigger <= 1'b1;
      cnt <= 3'h5;
    end else if (cnt != 3'h0) begin
      bus_trigger <= cnt > 3'h4;
      cnt <= cnt - 3'h1;
    end
  end
endmodule // htss_host_model

// *** verif/test_hold_trigger_state_store.sv ***
// Self-checking bench for the hold, trigger and state store block
`timescale 1ns/1ps
`include "htss_defines.vh"
module test_hold_trigger_state_store;
  reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  reg         pwrite = 1'b0, fire = 1'b0, err;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, q;
  wire [31:0] prdata;
  wire        pready, pslverr, bus_trigger, output_enable, irq;
  wire [15:0] vs, cs;
  wire [1:0]  trip;
  wire [7:0]  fm;
  integer     mismatches = 0, comparisons = 0;
  initial begin
    forever #50 pclk = ~pclk;
  end
  htss_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_trigger(bus_trigger), .voltage_setpoint(vs),
    .current_setpoint(cs), .mode_trip_shutdown(trip), .fault_mask(fm),
    .output_enable(output_enable), .irq(irq));
  htss_host_model i_host (.pclk(pclk), .presetn(presetn), .fire(fire),
    .bus_trigger(bus_trigger));
  // ******
  // Tasks
  // ******
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
    end
  endtask
  task wrc(input [3:0] c, input [7:0] n);
    apb(1'b1, `HTSS_CMD_OFF, {16'h0000, n, 4'h0, c});
  endtask
  task outs(input [31:0] vc, input [9:0] tm);
    begin
      chk({vs, cs}, vc);
      chk({trip, fm}, tm);
    end
  endtask
  task wrap_up;
    begin
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Whole run is about 120 cycles
  initial begin
    #400000;
    mismatches = mismatches + 1;
    wrap_up;
  end
  // ******
  // Tests
  // ******
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `HTSS_SETPT_OFF, 32'h1234_5678);
    outs(32'h1234_5678, 10'h000);
    wrc(`HTSS_CMD_HOLD_ON, 8'h00);
    apb(1'b1, `HTSS_SETPT_OFF, 32'hAAAA_5555);
    apb(1'b1, `HTSS_MISC_OFF, 32'h0000_015A);
    outs(32'h1234_5678, 10'h000);
    apb(1'b0, `HTSS_BUF_SETPT_OFF, 32'h0);
    chk(q, 32'hAAAA_5555);
    wrc(`HTSS_CMD_TRIGGER, 8'h00);
    outs(32'hAAAA_5555, 10'h15A);
    apb(1'b1, `HTSS_SETPT_OFF, 32'h1111_2222);
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (8) @(posedge pclk);
    #1;
    outs(32'h1111_2222, 10'h15A);
    wrc(`HTSS_CMD_HOLD_OFF, 8'h00);
    apb(1'b0, `HTSS_STATUS_OFF, 32'h0);
    chk(q[0], 32'h0);
    apb(1'b1, `HTSS_SETPT_OFF, 32'h0F0F_00F0);
    apb(1'b1, `HTSS_MISC_OFF, 32'h0000_0233);
    wrc(`HTSS_CMD_SAVE, 8'h0F);
    apb(1'b1, `HTSS_SETPT_OFF, 32'h0101_0202);
    apb(1'b1, `HTSS_MISC_OFF, 32'h0000_0000);
    wrc(`HTSS_CMD_OUT_ON, 8'h00);
    chk(output_enable, 32'h1);
    wrc(`HTSS_CMD_SAVE, 8'h01);
    apb(1'b1, `HTSS_SETPT_OFF, 32'h7777_7777);
    wrc(`HTSS_CMD_OUT_OFF, 8'h00);
    chk(output_enable, 32'h0);
    wrc(`HTSS_CMD_RESTORE, 8'h0F);
    outs(32'h0F0F_00F0, 10'h233);
    wrc(`HTSS_CMD_RESTORE, 8'h01);
    outs(32'h0101_0202, 10'h000);
    chk(output_enable, 32'h0);
    wrc(`HTSS_CMD_REINIT, 8'h00);
    outs(32'h0, 10'h000);
    wrc(`HTSS_CMD_RESTORE, 8'h0F);
    outs(32'h0F0F_00F0, 10'h233);
    apb(1'b0, `HTSS_IRQ_STAT_OFF, 32'h0);
    chk(q, 32'h7);
    apb(1'b1, `HTSS_IRQ_MASK_OFF, 32'h8);
    wrc(`HTSS_CMD_TRIGGER, 8'h00);
    chk(irq, 32'h0);
    wrc(`HTSS_CMD_SAVE, 8'h10);
    wrc(`HTSS_CMD_RESTORE, 8'h10);
    outs(32'h0F0F_00F0, 10'h233);
    apb(1'b0, `HTSS_STATUS_OFF, 32'h0);
    chk(q[7:4], `HTSS_ERR_RANGE);
    chk(irq, 32'h1);
    apb(1'b0, `HTSS_IRQ_STAT_OFF, 32'h0);
    chk(q, 32'h9);
    chk(irq, 32'h0);
    apb(1'b1, `HTSS_CTRL_OFF, 32'h2);
    apb(1'b0, `HTSS_STATUS_OFF, 32'h0);
    chk(q[7:4], `HTSS_ERR_NONE);
    // Pin trigger lands on the setup edge of a status read
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    @(posedge pclk);
    apb(1'b0, `HTSS_IRQ_STAT_OFF, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, `HTSS_IRQ_STAT_OFF, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, 12'h02C, 32'h0);
    chk(err, 32'h1);
    chk(q, 32'h0);
    wrap_up;
  end
endmodule // test_hold_trigger_state_store
